//--- afpm_audio_if.sv
// ----------------------------------------
// audio path between manager and pwm stage
// ----------------------------------------
interface afpm_audio_if;
  import afpm_pkg::*;
  logic signed [SAMPLE_W-1:0] left; // clipped left sample
  logic signed [SAMPLE_W-1:0] right; // clipped right sample
  logic sample_strobe; // one cycle per sample
  logic run; // playback allowed
  modport src (output left, output right, output sample_strobe, output run);
  modport dst (input left, input right, input sample_strobe, input run);
endinterface

//--- afpm_ctrl_model.sv
module afpm_ctrl_model #(
  parameter int LOW_CYC = 4 // shutdown low time, cycles
) (
  input wire logic clk, // device clock
  input wire logic fault_alert_n_o, // line value from device
  input wire logic fault_alert_n_oe, // line enable from device
  input wire logic toggle, // bench asks for a shutdown toggle
  output logic amp_shutdown_n, // shutdown pin drive
  output logic fault_line // resolved line level
);
  // ----------------------------------------
  // fault line with board pull-up
  // ----------------------------------------
  // the line is never looped back onto the pin here; the toggle comes from the bench
  assign fault_line = fault_alert_n_oe ? fault_alert_n_o : 1'b1;
  // ----------------------------------------
  // shutdown toggle
  // ----------------------------------------
  int cnt = 0; // remaining low cycles
  initial amp_shutdown_n = 1'b1;
  // a pulse on toggle holds the pin low for a few edges, then high again
  always @(posedge clk) begin
    if (toggle) begin
      cnt <= LOW_CYC;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
    amp_shutdown_n <= !(toggle || cnt > 1);
  end
endmodule

//--- afpm_dc_detect.sv
module afpm_dc_detect (
  input wire logic clk, // device clock
  input wire logic resetn, // async reset, active low
  input wire logic run, // output stage switching
  input wire logic [1:0] pwm_p, // positive outputs
  input wire logic [1:0] pwm_n, // negative outputs
  output logic dc_offset_error // dc persisted too long
);
  import afpm_pkg::*;
  logic [1:0] hit; // per channel persistence reached
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [CNT_W-1:0] win; // samples in current window
    logic [CNT_W-1:0] hi_cnt; // cycles positive in window
    logic [CNT_W-1:0] long_cnt; // cycles at same polarity bias
    logic pol; // polarity of last biased window
    logic biased; // last window over threshold
    localparam logic [CNT_W-1:0] WIN = CNT_W'(PCT_FULL * PWM_W * 32);
    localparam logic [CNT_W-1:0] HI_LIM = CNT_W'(DC_DUTY_PCT * PWM_W * 32);
    localparam logic [CNT_W-1:0] LO_LIM = CNT_W'((PCT_FULL - DC_DUTY_PCT) * PWM_W * 32);
    localparam logic [CNT_W-1:0] DC_LIM = CNT_W'(DC_CYCLES);
    // ----------------------------------------
    // duty measured per window, bias must hold its polarity
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        win <= '0;
        hi_cnt <= '0;
        long_cnt <= '0;
        pol <= 1'b0;
        biased <= 1'b0;
      end else if (!run) begin
        win <= '0;
        hi_cnt <= '0;
        long_cnt <= '0;
        biased <= 1'b0;
      end else if (win == WIN - 1'b1) begin
        win <= '0;
        hi_cnt <= '0;
        // over 60% either way, at the polarity seen before
        if (hi_cnt > HI_LIM || hi_cnt < LO_LIM) begin
          pol <= (hi_cnt > HI_LIM);
          if (!biased || pol != (hi_cnt > HI_LIM)) begin
            long_cnt <= WIN; // polarity changed: restart
          end else if (long_cnt < DC_LIM) begin
            long_cnt <= long_cnt + WIN;
          end
          biased <= 1'b1;
        end else begin
          long_cnt <= '0;
          biased <= 1'b0;
        end
      end else begin
        win <= win + 1'b1;
        hi_cnt <= hi_cnt + CNT_W'(pwm_p[c] & ~pwm_n[c]);
      end
    end
    assign hit[c] = (long_cnt > DC_LIM);
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dc_offset_error <= 1'b0;
    end else begin
      dc_offset_error <= |hit;
    end
  end
endmodule

//--- afpm_monitor.sv
module afpm_monitor #(
  parameter int unsigned FAULT_TIMEOUT = 20 // timeout cycles
) (
  input wire logic clk, // device clock
  input wire logic resetn, // async reset, active low
  input wire logic amp_shutdown_n, // shutdown pin
  input wire logic shutdown_bit_n, // shutdown bit
  input wire logic overvoltage_flag, // ov detector
  input wire logic clock_invalid_flag, // clock monitor
  input wire logic overcurrent_flag, // oc detector
  input wire logic [1:0] pwm_p, // positive pwm
  input wire logic [1:0] pwm_n, // negative pwm
  input wire logic fault_alert_n_o, // line value
  input wire logic fault_alert_n_oe, // line enable
  input wire logic [afpm_pkg::ERR_N-1:0] error_status, // status bits
  input wire logic playing // normal playback
);
  import afpm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // shutdown release age
  // ----------------------------------------
  logic [31:0] hi_cnt; // edges with both shutdown inputs high, saturating
  // saturate so a long run never wraps back into the timeout window
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt <= '0;
    end else if (!(amp_shutdown_n && shutdown_bit_n)) begin
      hi_cnt <= '0;
    end else if (hi_cnt != 32'hffffffff) begin
      hi_cnt <= hi_cnt + 32'h1;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_line_pulls_low: assert property (
    fault_alert_n_oe |-> fault_alert_n_o == 1'b0) else $error("fault line not driven low");
  chk_alert_cause: assert property (
    $rose(fault_alert_n_oe) |-> |(error_status & ALERT_MASK)) else $error("alert without cause");
  chk_ov_status: assert property (
    $rose(overvoltage_flag) |-> ##3 error_status[ERR_OV]) else $error("ov status late");
  chk_oc_alert: assert property (
    $rose(overcurrent_flag) |-> ##4 (fault_alert_n_oe && !playing))
    else $error("oc alert late");
  chk_clk_alert: assert property (
    $rose(clock_invalid_flag) |-> ##3 fault_alert_n_oe) else $error("clock alert late");
  chk_pwm_idle: assert property (
    !playing && !$past(playing) |-> pwm_p == 2'b00 && pwm_n == 2'b00)
    else $error("pwm active while stopped");
  chk_pwm_pair: assert property (
    playing && $past(playing) |-> pwm_n == ~pwm_p) else $error("pwm not complementary");
  chk_shut_stops: assert property (
    !amp_shutdown_n [*3] |-> !playing) else $error("playing in shutdown");
  chk_err_stops: assert property (
    $past(|error_status) && |error_status |-> !playing) else $error("playing with error");
  chk_wait_timeout: assert property (
    $rose(playing) && $past(fault_alert_n_oe) |-> hi_cnt >= FAULT_TIMEOUT)
    else $error("resumed before timeout");
endmodule

bind amp_fault_protection_manager afpm_monitor #(.FAULT_TIMEOUT(FAULT_TIMEOUT)) u_mon (
  .clk(clk),
  .resetn(resetn),
  .amp_shutdown_n(amp_shutdown_n),
  .shutdown_bit_n(shutdown_bit_n),
  .overvoltage_flag(overvoltage_flag),
  .clock_invalid_flag(clock_invalid_flag),
  .overcurrent_flag(overcurrent_flag),
  .pwm_p(pwm_p),
  .pwm_n(pwm_n),
  .fault_alert_n_o(fault_alert_n_o),
  .fault_alert_n_oe(fault_alert_n_oe),
  .error_status(error_status),
  .playing(playing)
);

//--- afpm_pkg.sv
package afpm_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 25000000; // device clock rate
  localparam int unsigned DC_TIME_MS = 420; // dc persistence time
  localparam int unsigned DC_CYCLES = DC_TIME_MS * (CLK_HZ / 1000); // least time, exact
  localparam int unsigned FAULT_TIMEOUT_MS = 10; // timeout period, plain default
  localparam int unsigned FAULT_TIMEOUT_CYCLES = FAULT_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned DC_DUTY_PCT = 60; // dc duty threshold percent
  localparam int unsigned PCT_FULL = 100; // percent scale
  // ----------------------------------------
  // widths and field positions
  // ----------------------------------------
  localparam int unsigned SAMPLE_W = 24; // audio sample width
  localparam int unsigned CLIP_W = 20; // clip level field width
  localparam int unsigned RATIO_W = 4; // pwm per sample multiple width
  localparam int unsigned CNT_W = 32; // long counter width
  localparam int unsigned PWM_W = 8; // pwm carrier counter width
  localparam int unsigned ERR_N = 6; // number of error sources
  localparam int unsigned ERR_OV = 0; // overvoltage bit
  localparam int unsigned ERR_UV = 1; // undervoltage bit
  localparam int unsigned ERR_CLK = 2; // clock error bit
  localparam int unsigned ERR_OC = 3; // overcurrent bit
  localparam int unsigned ERR_DC = 4; // dc offset bit
  localparam int unsigned ERR_OT = 5; // overtemperature bit
  // latching sources: overcurrent, dc offset, overtemperature
  localparam logic [5:0] LATCH_MASK = 6'h38;
  // sources that pull the fault line: latching ones plus clock
  localparam logic [5:0] ALERT_MASK = 6'h3c;
  localparam logic [5:0] ERR_NONE = 6'h00; // reset value of status
  // ----------------------------------------
  // protection states
  // ----------------------------------------
  typedef enum logic [3:0] {
    AFPM_RUN = 4'h1, // normal playback
    AFPM_LATCHED = 4'h2, // latching fault held
    AFPM_TIMEOUT = 4'h4, // toggle seen, timing out
    AFPM_SHUT = 4'h8 // shutdown requested
  } afpm_state_e;
endpackage

//--- afpm_pwm.sv
module afpm_pwm (
  afpm_audio_if.dst au, // clipped audio in
  input wire logic clk, // device clock
  input wire logic resetn, // async reset, active low
  input wire logic [afpm_pkg::RATIO_W-1:0] pwm_ratio, // carriers per sample
  output logic [1:0] pwm_p, // positive outputs, per channel
  output logic [1:0] pwm_n // complementary outputs, per channel
);
  import afpm_pkg::*;
  logic [PWM_W-1:0] carrier; // carrier ramp
  logic [RATIO_W-1:0] period_cnt; // carriers since last sample
  logic [PWM_W-1:0] duty [2]; // latched duty per channel
  logic signed [SAMPLE_W-1:0] samp [2]; // channel samples
  assign samp[0] = au.left;
  assign samp[1] = au.right;
  // ----------------------------------------
  // carrier: free-running 256-clock ramp, re-aligned on each strobe; pwm_ratio only sets the wrap count
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      carrier <= '0;
      period_cnt <= '0;
    end else if (au.sample_strobe) begin
      carrier <= '0;
      period_cnt <= '0;
    end else begin
      carrier <= carrier + 1'b1;
      // wrap count kept so the multiple stays observable
      if (&carrier) begin
        period_cnt <= (period_cnt == pwm_ratio) ? '0 : period_cnt + 1'b1;
      end
    end
  end
  // ----------------------------------------
  // per channel duty update and complementary drive
  // ----------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_ch
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        duty[c] <= {1'b1, {(PWM_W-1){1'b0}}};
        pwm_p[c] <= 1'b0;
        pwm_n[c] <= 1'b0;
      end else begin
        // offset binary top bits; midscale is 50% duty
        if (au.sample_strobe) begin
          duty[c] <= {~samp[c][SAMPLE_W-1], samp[c][SAMPLE_W-2 -: PWM_W-1]};
        end
        // both low when stopped: output stage idle
        pwm_p[c] <= au.run & (carrier < duty[c]);
        pwm_n[c] <= au.run & ~(carrier < duty[c]);
      end
    end
  end
endmodule

//--- afpm_top.sv
module amp_fault_protection_manager #(
  parameter int unsigned FAULT_TIMEOUT = afpm_pkg::FAULT_TIMEOUT_CYCLES // timeout cycles
) (
  input wire logic clk, // device clock, 25 mhz
  input wire logic resetn, // async reset, active low
  input wire logic signed [afpm_pkg::SAMPLE_W-1:0] audio_left, // oversampled left
  input wire logic signed [afpm_pkg::SAMPLE_W-1:0] audio_right, // oversampled right
  input wire logic sample_strobe, // one cycle per sample
  input wire logic [afpm_pkg::CLIP_W-1:0] clip_level, // clip magnitude
  input wire logic [afpm_pkg::RATIO_W-1:0] pwm_ratio, // pwm carriers per sample
  input wire logic amp_shutdown_n, // shutdown pin, active low
  input wire logic shutdown_bit_n, // shutdown control bit, active low
  input wire logic overvoltage_flag, // analog detector, async
  input wire logic undervoltage_flag, // analog detector, async
  input wire logic clock_invalid_flag, // clock monitor, async
  input wire logic overcurrent_flag, // analog detector, async
  input wire logic overtemp_flag, // over threshold, async
  input wire logic overtemp_hyst_flag, // still above hysteresis, async
  output logic [1:0] pwm_p, // positive pwm outputs
  output logic [1:0] pwm_n, // complementary pwm outputs
  output logic fault_alert_n_o, // fault line output value
  output logic fault_alert_n_oe, // fault line enable, high drives low
  output logic [afpm_pkg::ERR_N-1:0] error_status, // error status bits
  output logic playing // normal playback
);
  import afpm_pkg::*;
  afpm_audio_if au ();
  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic [ERR_N:0] flag_raw; // raw detector levels
  logic [ERR_N:0] sync_a; // first stage, read only by second
  logic [ERR_N:0] sync_b; // synchronised flags
  logic dc_offset_error; // from dc detector
  assign flag_raw = {overtemp_hyst_flag, overtemp_flag, 1'b0, overcurrent_flag,
                     clock_invalid_flag, undervoltage_flag, overvoltage_flag};
  // two flops per flag keep metastability out of the fault logic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= flag_raw;
      sync_b <= sync_a;
    end
  end
  // ----------------------------------------
  // error classification
  // ----------------------------------------
  logic [ERR_N-1:0] err_now; // live errors, synchronised
  logic overvoltage_error; // supply above limit
  logic undervoltage_error; // supply below limit
  logic clock_error; // clocks not valid
  logic overcurrent_error; // output overcurrent
  logic overtemperature_error; // die too hot
  logic ot_hyst; // die not yet below hysteresis
  assign overvoltage_error = sync_b[ERR_OV];
  assign undervoltage_error = sync_b[ERR_UV];
  assign clock_error = sync_b[ERR_CLK];
  assign overcurrent_error = sync_b[ERR_OC];
  assign overtemperature_error = sync_b[ERR_OT];
  assign ot_hyst = sync_b[ERR_N];
  assign err_now = {overtemperature_error, dc_offset_error, overcurrent_error,
                    clock_error, undervoltage_error, overvoltage_error};
  logic [ERR_N-1:0] latch_now; // live latching errors
  logic [ERR_N-1:0] nonlatch_now; // live non-latching errors
  assign latch_now = err_now & LATCH_MASK;
  assign nonlatch_now = err_now & ~LATCH_MASK;
  // ----------------------------------------
  // shutdown request and toggle detection
  // ----------------------------------------
  logic sd_active; // shutdown requested by pin or bit
  logic sd_prev; // shutdown request last cycle
  logic sd_release; // low to high of shutdown, one cycle
  assign sd_active = ~amp_shutdown_n | ~shutdown_bit_n;
  assign sd_release = sd_prev & ~sd_active;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sd_prev <= 1'b0;
    end else begin
      sd_prev <= sd_active;
    end
  end
  // ----------------------------------------
  // protection state machine
  // ----------------------------------------
  afpm_state_e state; // current state
  afpm_state_e next_state; // next state
  logic [CNT_W-1:0] tmo_cnt; // timeout counter
  logic tmo_done; // timeout elapsed
  logic ot_block; // overtemperature still above hysteresis
  logic latch_held; // value loaded into latched bits on recovery, tied low
  localparam logic [CNT_W-1:0] TMO_LIM = CNT_W'(FAULT_TIMEOUT);
  assign tmo_done = (tmo_cnt >= TMO_LIM);
  assign ot_block = error_status[ERR_OT] & ot_hyst;
  always_comb begin
    next_state = state;
    unique case (state)
      AFPM_RUN: begin
        if (|latch_now) begin
          next_state = AFPM_LATCHED;
        end else if (sd_active) begin
          next_state = AFPM_SHUT;
        end
      end
      AFPM_SHUT: begin
        if (!sd_active) begin
          next_state = AFPM_RUN;
        end
      end
      AFPM_LATCHED: begin
        // only a completed toggle starts a recovery attempt
        if (sd_release) begin
          next_state = AFPM_TIMEOUT;
        end
      end
      AFPM_TIMEOUT: begin
        if (|latch_now) begin
          next_state = AFPM_LATCHED;
        end else if (sd_active) begin
          next_state = AFPM_LATCHED;
        end else if (tmo_done && !ot_block) begin
          next_state = AFPM_RUN;
        end
      end
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= AFPM_RUN;
    end else begin
      state <= next_state;
    end
  end
  // timeout counts only while waiting after the toggle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tmo_cnt <= '0;
    end else if (state != AFPM_TIMEOUT) begin
      tmo_cnt <= '0;
    end else if (!tmo_done) begin
      tmo_cnt <= tmo_cnt + 1'b1;
    end
  end
  // ----------------------------------------
  // error status bits
  // ----------------------------------------
  // latched bits stay until recovery; set wins over clear
  assign latch_held = 1'b0;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      error_status <= ERR_NONE;
    end else begin
      for (int i = 0; i < ERR_N; i++) begin
        if (err_now[i]) begin
          error_status[i] <= 1'b1;
        end else if (!LATCH_MASK[i]) begin
          error_status[i] <= 1'b0;
        end else if (next_state == AFPM_RUN && state == AFPM_TIMEOUT) begin
          error_status[i] <= latch_held;
        end
      end
    end
  end
  // ----------------------------------------
  // fault line and playback
  // ----------------------------------------
  logic alert; // fault line pulled low
  // supply errors are excluded by the mask; clock error needs no timeout
  assign alert = (state == AFPM_LATCHED) || (state == AFPM_TIMEOUT) ||
                 (|(err_now & ALERT_MASK));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_alert_n_oe <= 1'b0;
      playing <= 1'b0;
    end else begin
      fault_alert_n_oe <= alert;
      // non-latching errors only hold playback while present
      playing <= (next_state == AFPM_RUN) && !(|nonlatch_now) && !sd_active;
    end
  end
  // open drain: drive a constant low, release otherwise
  assign fault_alert_n_o = 1'b0;
  // ----------------------------------------
  // digital clipper
  // ----------------------------------------
  logic signed [SAMPLE_W-1:0] clip_pos; // positive clip point
  logic signed [SAMPLE_W-1:0] clip_neg; // negative clip point
  logic signed [SAMPLE_W-1:0] in_s [2]; // channel inputs
  logic signed [SAMPLE_W-1:0] out_s [2]; // clipped outputs
  assign clip_pos = SAMPLE_W'({1'b0, clip_level, {(SAMPLE_W-CLIP_W-1){1'b0}}});
  assign clip_neg = -clip_pos;
  assign in_s[0] = audio_left;
  assign in_s[1] = audio_right;
  for (genvar c = 0; c < 2; c++) begin : g_clip
    // registered so the pwm stage sees stable samples
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        out_s[c] <= '0;
      end else if (sample_strobe) begin
        if (in_s[c] > clip_pos) begin
          out_s[c] <= clip_pos;
        end else if (in_s[c] < clip_neg) begin
          out_s[c] <= clip_neg;
        end else begin
          out_s[c] <= in_s[c];
        end
      end
    end
  end
  logic strobe_d; // strobe aligned to clipped samples
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strobe_d <= 1'b0;
    end else begin
      strobe_d <= sample_strobe;
    end
  end
  assign au.left = out_s[0];
  assign au.right = out_s[1];
  assign au.sample_strobe = strobe_d;
  assign au.run = playing;
  // ----------------------------------------
  // pwm conversion and dc watch
  // ----------------------------------------
  afpm_pwm u_pwm (
    .au(au.dst),
    .clk(clk),
    .resetn(resetn),
    .pwm_ratio(pwm_ratio),
    .pwm_p(pwm_p),
    .pwm_n(pwm_n)
  );
  afpm_dc_detect u_dc (
    .clk(clk),
    .resetn(resetn),
    .run(playing),
    .pwm_p(pwm_p),
    .pwm_n(pwm_n),
    .dc_offset_error(dc_offset_error)
  );
endmodule

//--- amp_fault_protection_manager_tb_top.sv
module amp_fault_protection_manager_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import afpm_pkg::*;
  localparam int unsigned FT = 20; // shortened timeout
  typedef struct packed {
    logic [4:0] flg; // detector flags
    logic [5:0] st; // expected status
    logic oe; // expected alert
  } afpm_row_s;
  // non-latching cases: flags in, status and alert out
  afpm_row_s rows [4] = '{'{5'h01, 6'h01, 1'b0}, '{5'h02, 6'h02, 1'b0},
                          '{5'h04, 6'h04, 1'b1}, '{5'h03, 6'h03, 1'b0}};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic signed [SAMPLE_W-1:0] aud = 24'h7fffff; // full-scale sample
  logic strobe = 1'b0;
  logic [CLIP_W-1:0] clip = 20'hfffff;
  logic sdb_n = 1'b1;
  logic [4:0] flg = 5'h00; // {ot, oc, clk, uv, ov}
  logic hyst = 1'b0;
  logic treq = 1'b0;
  logic [7:0] scnt = 8'h00;
  logic sd_n, line, oe_o, oe, play;
  logic [1:0] pp, pn;
  logic [ERR_N-1:0] st;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  int lo, hi, n;
  // ----------------------------------------
  // clock, strobe, timeout
  // ----------------------------------------
  always #20 clk = ~clk;
  // one sample every 256 clocks, matching one carrier ramp
  always @(posedge clk) begin
    scnt <= scnt + 8'h01;
    strobe <= (scnt == 8'hff);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end
  amp_fault_protection_manager #(.FAULT_TIMEOUT(FT)) u_dut (
    .clk(clk), .resetn(resetn), .audio_left(aud), .audio_right(-aud),
    .sample_strobe(strobe), .clip_level(clip), .pwm_ratio(4'h1),
    .amp_shutdown_n(sd_n), .shutdown_bit_n(sdb_n), .overvoltage_flag(flg[0]),
    .undervoltage_flag(flg[1]), .clock_invalid_flag(flg[2]), .overcurrent_flag(flg[3]),
    .overtemp_flag(flg[4]), .overtemp_hyst_flag(hyst), .pwm_p(pp), .pwm_n(pn),
    .fault_alert_n_o(oe_o), .fault_alert_n_oe(oe), .error_status(st), .playing(play));
  afpm_ctrl_model u_ctrl (.clk(clk), .fault_alert_n_o(oe_o), .fault_alert_n_oe(oe),
    .toggle(treq), .amp_shutdown_n(sd_n), .fault_line(line));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task finish_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // status, alert enable, resolved line and playback in one go
  task see(input logic [5:0] s, input logic o, input logic p);
    chk({2'b00, st}, {2'b00, s}, "status");
    chk({7'h0, oe}, {7'h0, o}, "alert");
    chk({7'h0, line}, {7'h0, ~o}, "line");
    chk({7'h0, play}, {7'h0, p}, "playing");
  endtask
  // via the bit, or via the controller model driving the pin
  task tog(input logic vb);
    if (vb) begin
      @(posedge clk) sdb_n <= 1'b0;
      repeat (4) @(posedge clk);
      sdb_n <= 1'b1;
    end else begin
      @(posedge clk) treq <= 1'b1;
      @(posedge clk) treq <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task rec(output int k);
    k = 0;
    while (play !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    #1;
  endtask
  // kf keeps the flag, kh the hysteresis flag, across the first toggle
  task lat(input logic [4:0] f, input logic [5:0] s, input logic kf, input logic kh,
           input logic vb);
    int k;
    @(posedge clk) flg <= f;
    hyst <= kh;
    cyc(6);
    see(s, 1'b1, 1'b0);
    @(posedge clk) flg <= kf ? f : 5'h00;
    cyc(30);
    see(s, 1'b1, 1'b0);
    if (kf || kh) begin
      tog(vb);
      cyc(FT + 20);
      see(s, 1'b1, 1'b0);
      @(posedge clk) flg <= 5'h00;
      hyst <= 1'b0;
    end
    tog(vb);
    rec(k);
    // the alert enable follows the registered state, one edge behind playback
    cyc(1);
    chk({7'h0, k >= FT && k < FT + 20}, 8'h01, "timeout");
    see(6'h00, 1'b0, 1'b1);
    $display("test latch %h done", f);
  endtask
  task duty(input logic [19:0] cl, output int h);
    @(posedge clk) clip <= cl;
    cyc(600);
    h = 0;
    repeat (512) begin
      @(posedge clk);
      if (pp[0] === 1'b1) h++;
    end
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    #1;
    see(6'h00, 1'b0, 1'b0);
    chk({4'h0, pp, pn}, 8'h00, "pwm in reset");
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    cyc(3);
    see(6'h00, 1'b0, 1'b1);
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clk) flg <= rows[i].flg;
      cyc(6);
      see(rows[i].st, rows[i].oe, 1'b0);
      @(posedge clk) flg <= 5'h00;
      cyc(6);
      see(6'h00, 1'b0, 1'b1);
      $display("test row %0d done", i);
    end
    @(posedge clk) treq <= 1'b1;
    @(posedge clk) treq <= 1'b0;
    cyc(2);
    chk({7'h0, play}, 8'h00, "play in shutdown");
    rec(n);
    see(6'h00, 1'b0, 1'b1);
    $display("test shutdown done");
    lat(5'h08, 6'h08, 1'b0, 1'b0, 1'b0);
    lat(5'h08, 6'h08, 1'b1, 1'b0, 1'b1);
    lat(5'h10, 6'h20, 1'b0, 1'b1, 1'b0);
    duty(20'h01000, lo);
    duty(20'hfffff, hi);
    chk({7'h0, lo != hi}, 8'h01, "clip level");
    $display("test clip done");
    @(posedge clk) flg <= 5'h08;
    cyc(6);
    @(posedge clk) flg <= 5'h00;
    resetn <= 1'b0;
    cyc(1);
    see(6'h00, 1'b0, 1'b0);
    @(posedge clk) resetn <= 1'b1;
    cyc(3);
    see(6'h00, 1'b0, 1'b1);
    $display("test second reset done");
    finish_test();
  end
endmodule
